/* hdl/aoxl_unit.sv */
// Accumulator logic unit for OR and exclusive-OR with word, double, bit-run and stack operands.
// Assumes the sequencer fetches memory operands and holds them valid with OP_VALID for one cycle.
module aoxl_unit
    import aoxl_pkg::*;
#(
    parameter int BITS = 4096
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RST_N,
    input  wire logic                OP_VALID,
    input  wire aoxl_pkg::aoxl_op_t  OP_CODE,
    input  wire logic [31:0]         OP_DATA,
    input  wire logic [BITS-1:0]     BIT_MEM,
    input  wire logic [11:0]         BIT_START,
    input  wire logic [5:0]          BIT_COUNT,
    output logic                     OP_DONE,
    output logic                     OP_ERROR,
    output logic [31:0]              ACCUMULATOR,
    output logic [31:0]              STACK_TOP,
    output logic [3:0]               STACK_DEPTH,
    output logic                     ZERO_RESULT_FLAG,
    output logic                     NEGATIVE_RESULT_FLAG
);
    import aoxl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Operation decoding, shared by the data path and the status logic.

    // True for the two forms that take a run of discrete bits.
    function automatic logic op_is_run(input aoxl_op_t code);
        return (code == OP_OR_WITH_BIT_RUN) || (code == OP_EXCLUSIVE_OR_BIT_RUN);
    endfunction

    // True for the two forms that take stack level one and pop it.
    function automatic logic op_is_stack(input aoxl_op_t code);
        return (code == OP_OR_WITH_STACK_TOP) || (code == OP_EXCLUSIVE_OR_STACK_TOP);
    endfunction

    // True for the two single-word forms that work on the low half only.
    function automatic logic op_is_word(input aoxl_op_t code);
        return (code == OP_OR_WORD) || (code == OP_EXCLUSIVE_OR_WORD);
    endfunction

    // Bit 2 of a logic code picks exclusive-OR over inclusive-OR.
    function automatic logic op_is_xor(input aoxl_op_t code);
        return code[2] && !code[3];
    endfunction

    // The eight logic forms occupy codes 0 to 7; load and push sit above them.
    function automatic logic op_is_logic(input aoxl_op_t code);
        return !code[3];
    endfunction

    // Codes beyond push are never issued by a sound sequencer.
    function automatic logic op_is_legal(input aoxl_op_t code);
        return code <= OP_PUSH;
    endfunction

    // A bit run holds one to thirty-two bits; anything else is refused.
    function automatic logic count_in_range(input logic [CNT_W-1:0] c);
        return (c >= CNT_MIN) && (c <= CNT_MAX);
    endfunction

    // Keeps the low word of a value and clears the upper half.
    function automatic logic [ACC_W-1:0] low_word(input logic [ACC_W-1:0] v);
        return {16'h0000, v[WORD_W-1:0]};
    endfunction

    // One merge serves both the inclusive and the exclusive forms.
    function automatic logic [ACC_W-1:0] merge(input logic [ACC_W-1:0] a,
                                               input logic [ACC_W-1:0] b,
                                               input logic             use_xor);
        return use_xor ? (a ^ b) : (a | b);
    endfunction

    // True when every bit of the value is clear.
    function automatic logic is_zero(input logic [ACC_W-1:0] v);
        return v == '0;
    endfunction

    // Depth after a push; a full stack drops its bottom entry and stays full.
    function automatic logic [3:0] depth_up(input logic [3:0] d);
        return (d == 4'(STACK_D)) ? d : d + 4'h1;
    endfunction

    // Depth after a pop; popping an empty stack leaves it empty.
    function automatic logic [3:0] depth_down(input logic [3:0] d);
        return (d == 4'h0) ? d : d - 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage: the accumulator stack and its fill level.
    logic [ACC_W-1:0] stack [STACK_D];
    logic [3:0]       depth;
    logic [ACC_W-1:0] run_operand;

    aoxl_bit_gather #(.BITS(BITS)) u_gather (
        .bit_mem (BIT_MEM),
        .start   (BIT_START),
        .count   (BIT_COUNT),
        .operand (run_operand)
    );

    // Decoded view of the operation offered on the inputs this cycle.
    wire is_run      = op_is_run(OP_CODE);
    wire is_stack    = op_is_stack(OP_CODE);
    wire is_word     = op_is_word(OP_CODE);
    wire is_push     = (OP_CODE == OP_PUSH);
    wire is_load     = (OP_CODE == OP_LOAD);
    wire is_xor      = op_is_xor(OP_CODE);

    // A bit-run form with a count outside one to thirty-two is refused whole,
    // as is any code the sequencer should never issue. Nothing then changes.
    wire count_bad   = is_run && !count_in_range(BIT_COUNT);
    wire legal_code  = op_is_legal(OP_CODE);
    wire reject      = OP_VALID && (count_bad || !legal_code);
    wire accept      = OP_VALID && !reject;

    // Load and push move data only; the flags belong to the logic forms.
    wire logic_op    = accept && op_is_logic(OP_CODE);

    // Single-word forms only see the low 16 bits of both sides, so the upper
    // half of the accumulator comes back cleared after them.
    wire [ACC_W-1:0] word_opnd   = low_word(OP_DATA);
    wire [ACC_W-1:0] word_acc    = low_word(ACCUMULATOR);

    // Second operand: bit run, stack level one, memory word or double word.
    wire [ACC_W-1:0] deep_opnd   = is_stack ? stack[0] : OP_DATA;
    wire [ACC_W-1:0] flat_opnd   = is_word ? word_opnd : deep_opnd;
    wire [ACC_W-1:0] operand     = is_run ? run_operand : flat_opnd;
    wire [ACC_W-1:0] acc_in      = is_word ? word_acc : ACCUMULATOR;

    // The same merge feeds the accumulator and both status flags.
    wire [ACC_W-1:0] result      = merge(acc_in, operand, is_xor);

    // Load takes the data word; push leaves the accumulator as it is.
    wire [ACC_W-1:0] next_acc    = is_load ? OP_DATA : (is_push ? ACCUMULATOR : result);

    // Single-word forms leave the negative flag alone.
    wire             sets_neg    = !is_word;
    wire             result_zero = is_zero(result);

    ////////////////////////////////////////////////////////////////////////////
    // The accumulator changes only on an accepted operation other than push.
    // A refused operation leaves it exactly as it was.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ACCUMULATOR <= ACC_RESET;
        end else if (accept && !is_push) begin
            ACCUMULATOR <= next_acc;
        end
    end

    // Flags change only on a logic operation and otherwise hold.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ZERO_RESULT_FLAG     <= 1'b0;
            NEGATIVE_RESULT_FLAG <= 1'b0;
        end else if (logic_op) begin
            ZERO_RESULT_FLAG <= result_zero;
            if (sets_neg) begin
                NEGATIVE_RESULT_FLAG <= result[ACC_W-1];
            end
        end
    end

    // Push on load or explicit push; pop on the stack forms.
    // A push onto a full stack loses the bottom entry, and a pop refills the
    // bottom with zero, so an empty stack always reads as zero at level one.
    // Load pushes the old accumulator on the same clock edge as the new value lands.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < STACK_D; i++) begin
                stack[i] <= ACC_RESET;
            end
            depth <= 4'h0;
        end else if (accept && (is_load || is_push)) begin
            stack[0] <= ACCUMULATOR;
            for (int i = 1; i < STACK_D; i++) begin
                stack[i] <= stack[i-1];
            end
            depth <= depth_up(depth);
        end else if (accept && is_stack) begin
            for (int i = 0; i < STACK_D - 1; i++) begin
                stack[i] <= stack[i+1];
            end
            stack[STACK_D-1] <= ACC_RESET;
            depth <= depth_down(depth);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            OP_DONE  <= 1'b0;
            OP_ERROR <= 1'b0;
        end else begin
            OP_DONE  <= accept;
            OP_ERROR <= reject;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level one and the fill level are visible to the sequencer for its own
    // bookkeeping; both come straight from flip-flops.
    assign STACK_TOP   = stack[0];
    assign STACK_DEPTH = depth;
endmodule

/* common/aoxl_pkg.sv */
// Package for the accumulator OR / XOR logic unit: opcodes, widths, reset values.
// Assumes one system clock and an instruction sequencer that issues one operation at a time.
// How it works
// - Bit-run OR merges one to thirty-two discrete bits into the accumulator.
// - Bit-run operations take a start bit address and a count from one to thirty-two.
// - Bit-run OR reports both zero and negative results.
// - Every OR and XOR form sets the zero flag when the result is zero.
// - Double, bit-run and stack forms set the negative flag from result bit 31.
// - Flags hold their value until a later operation updates the same flag.
// - Stack OR merges the full accumulator with stack level one.
// - Stack forms pop the stack; every other entry moves up one level.
// - Single-word XOR combines the low 16 accumulator bits with one memory word.
// - Single-word XOR updates only the zero flag.
// - Double-word XOR uses two memory words or a 32-bit constant.
// - Bit-run XOR combines the accumulator with one to thirty-two bits.
// - Stack XOR combines the full accumulator with stack level one.
package aoxl_pkg;
    localparam int ACC_W      = 32;
    localparam int WORD_W     = 16;
    localparam int CNT_W      = 6;
    localparam int STACK_D    = 8;
    localparam int BADDR_W    = 12;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [5:0]  CNT_MIN   = 6'h01;
    localparam logic [5:0]  CNT_MAX   = 6'h20;

    typedef enum logic [3:0] {
        OP_OR_WORD                  = 4'h0,
        OP_OR_DOUBLE_WORD           = 4'h1,
        OP_OR_WITH_BIT_RUN          = 4'h2,
        OP_OR_WITH_STACK_TOP        = 4'h3,
        OP_EXCLUSIVE_OR_WORD        = 4'h4,
        OP_EXCLUSIVE_OR_DOUBLE_WORD = 4'h5,
        OP_EXCLUSIVE_OR_BIT_RUN     = 4'h6,
        OP_EXCLUSIVE_OR_STACK_TOP   = 4'h7,
        OP_LOAD                     = 4'h8,
        OP_PUSH                     = 4'h9
    } aoxl_op_t;
endpackage

/* hdl/aoxl_bit_gather.sv */
// Gathers a run of discrete bits into a 32-bit operand.
// Assumes the bit memory is presented whole and the count is already range checked.
module aoxl_bit_gather
    import aoxl_pkg::*;
#(
    parameter int BITS = 4096
) (
    input  wire logic [BITS-1:0]    bit_mem,
    input  wire logic [BADDR_W-1:0] start,
    input  wire logic [CNT_W-1:0]   count,
    output logic      [ACC_W-1:0]   operand
);
    always_comb begin
        operand = '0;
        for (int i = 0; i < ACC_W; i++) begin
            if (i < int'(count)) begin
                operand[i] = bit_mem[(int'(start) + i) % BITS];
            end
        end
    end
endmodule

/* verification/aoxl_chk_properties.sv */
// Checker for the OR / XOR logic unit, bound to its top module.
// Assumes the unit's single clock and active-low reset.
module aoxl_chk import aoxl_pkg::*; (
    input wire logic               CLK_SYS,
    input wire logic               RST_N,
    input wire logic               OP_VALID,
    input wire aoxl_pkg::aoxl_op_t OP_CODE,
    input wire logic [5:0]         BIT_COUNT,
    input wire logic               OP_DONE,
    input wire logic               OP_ERROR,
    input wire logic [31:0]        ACCUMULATOR,
    input wire logic [31:0]        STACK_TOP,
    input wire logic [3:0]         STACK_DEPTH,
    input wire logic               ZERO_RESULT_FLAG,
    input wire logic               NEGATIVE_RESULT_FLAG
);
    wire bad = (OP_CODE[1:0] == 2'h2 && !OP_CODE[3] && (BIT_COUNT == 6'h00 || BIT_COUNT > 6'h20))
        || (OP_CODE > OP_PUSH);
    wire lgc = OP_VALID && !bad && !OP_CODE[3];
    wire wrd = lgc && OP_CODE[1:0] == 2'h0;
    wire stk = lgc && OP_CODE[1:0] == 2'h3;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    op_done_a: assert property (OP_VALID && !bad |=> OP_DONE && !OP_ERROR) else $error("no done");
    op_refuse_a: assert property (OP_VALID && bad |=> OP_ERROR && $stable(ACCUMULATOR)) else $error("no refusal");
    zero_flag_a: assert property (lgc |=> ZERO_RESULT_FLAG == (ACCUMULATOR == 32'h0)) else $error("zero flag");
    neg_flag_a: assert property (lgc && !wrd |=> NEGATIVE_RESULT_FLAG == ACCUMULATOR[31]) else $error("neg flag");
    word_neg_a: assert property (wrd |=> $stable(NEGATIVE_RESULT_FLAG)) else $error("word neg flag");
    idle_hold_a: assert property (!OP_VALID |=> $stable(ACCUMULATOR) && $stable(ZERO_RESULT_FLAG))
        else $error("not held");
    stack_or_a: assert property (stk && !OP_CODE[2] |=> ACCUMULATOR == ($past(ACCUMULATOR) | $past(STACK_TOP)))
        else $error("stack or");
    stack_pop_a: assert property (stk && STACK_DEPTH != 4'h0 |=> STACK_DEPTH == $past(STACK_DEPTH) - 4'h1)
        else $error("no pop");
endmodule
bind aoxl_unit aoxl_chk u_chk (.*);

/* verification/aoxl_mem_model.sv */
// Bit memory and data word source standing for the sequencer side.
// Assumes the bench hands in a fresh random word every cycle.
module aoxl_mem_model (
    input  wire logic        clk,
    input  wire logic [31:0] fresh,
    output logic      [63:0] bits,
    output logic      [31:0] word
);
    always_ff @(posedge clk) begin
        bits <= {bits[31:0], fresh};
        word <= fresh ^ bits[63:32];
    end
endmodule

/* verification/tb_aoxl_unit.sv */
// Self-checking bench for the OR / XOR logic unit with a reference model.
// Assumes the memory model supplies bit memory and data words.
module tb_aoxl_unit import aoxl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, vld = 0, ok, dn, er, zo, no, zf = 0, nf = 0;
    aoxl_op_t op = OP_LOAD;
    logic [31:0] fr = 0, wd, ac, acc = 0, x, t, r, tp;
    logic [63:0] bm;
    logic [11:0] st = 0;
    logic [5:0] cn = 6'h01;
    logic [3:0] dp;
    logic [31:0] stk[$];
    int bad_count = 0, num_checks = 0, seed = 32'h032B754F;
    initial forever #5 clk = ~clk;
    aoxl_mem_model mem (.clk(clk), .fresh(fr), .bits(bm), .word(wd));
    aoxl_unit #(.BITS(64)) dut (.CLK_SYS(clk), .RST_N(rst_n), .OP_VALID(vld), .OP_CODE(op), .OP_DATA(wd),
        .BIT_MEM(bm), .BIT_START(st), .BIT_COUNT(cn), .OP_DONE(dn), .OP_ERROR(er), .ACCUMULATOR(ac),
        .STACK_TOP(tp), .STACK_DEPTH(dp), .ZERO_RESULT_FLAG(zo), .NEGATIVE_RESULT_FLAG(no));
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] gather(input int s, c);
        for (int i = 0; i < 32; i++) gather[i] = i < c && bm[(s + i) % 64];
    endfunction
    task automatic do_op(input aoxl_op_t o, input logic [11:0] s, input logic [5:0] c, input logic v = 1);
        op = o;
        st = s;
        cn = c;
        vld = v;
        fr = $random(seed);
        ok = v && (o <= OP_PUSH) && (o[3] || o[1:0] != 2'h2 || (c != 6'h00 && c <= 6'h20));
        x = o[0] ? (o[1] ? (stk.size() ? stk[0] : 32'h0) : wd) : (o[1] ? gather(s, c) : wd);
        t = (o[2] ? acc ^ x : acc | x) & (o[1:0] == 2'h0 ? 32'h0000FFFF : 32'hFFFFFFFF);
        @(posedge clk);
        #1;
        if (ok && o[3]) stk.push_front(acc);
        if (ok && o == OP_LOAD) acc = x;
        if (ok && !o[3]) begin
            acc = t;
            zf = t == 32'h0;
            nf = o[1:0] != 2'h0 ? t[31] : nf;
            if (o[1:0] == 2'h3 && stk.size()) void'(stk.pop_front());
        end
        if (stk.size() > 8) void'(stk.pop_back());
        chk("resp", {ok, v && !ok}, {dn, er});
        chk("top", stk.size() ? stk[0] : 32'h0, tp);
        chk("acc", acc, ac);
        chk("zero", zf, zo);
        chk("neg", nf, no);
        chk("depth", stk.size(), dp);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        repeat (9) do_op(OP_LOAD, 0, 1);
        repeat (2) do_op(OP_EXCLUSIVE_OR_STACK_TOP, 0, 1);
        repeat (9) do_op(OP_OR_WITH_STACK_TOP, 0, 1);
        do_op(OP_PUSH, 0, 1);
        do_op(OP_EXCLUSIVE_OR_STACK_TOP, 0, 1);
        for (int k = 0; k < 10; k++) do_op(aoxl_op_t'(4'(k)), 12'hFFE, 6'h20);
        do_op(OP_EXCLUSIVE_OR_BIT_RUN, 12'h03F, 6'h01);
        do_op(OP_OR_WITH_BIT_RUN, 0, 6'h21);
        do_op(OP_EXCLUSIVE_OR_BIT_RUN, 0, 6'h00);
        do_op(aoxl_op_t'(4'hA), 0, 6'h01);
        do_op(OP_OR_WORD, 0, 6'h01, 1'b0);
        repeat (400) begin
            r = $random(seed);
            do_op(aoxl_op_t'(4'(r % 10)), r[15:4], r[21:16], r[31:29] != 3'h0);
        end
        give_verdict();
    end
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule
